// [fgpio_pkg.sv]
// Package holding the address map, reset values and sizes of the fast GPIO block
package fgpio_pkg;

    // Geometry
    localparam int          FGPIO_NUM_BANKS   = 3;
    localparam int          FGPIO_BANK_WIDTH  = 32;
    localparam int          FGPIO_ADDR_WIDTH  = 8;

    // Address space selector (byte address bit 7)
    localparam int          FGPIO_LEGACY_BIT  = 7;

    // Fast map: byte address = bank * 0x20 + register offset
    localparam int          FGPIO_FAST_BANK_LSB = 5;
    localparam logic [2:0]  FGPIO_FAST_DIR    = 3'h0;
    localparam logic [2:0]  FGPIO_FAST_MASK   = 3'h1;
    localparam logic [2:0]  FGPIO_FAST_PIN    = 3'h2;
    localparam logic [2:0]  FGPIO_FAST_SET    = 3'h3;
    localparam logic [2:0]  FGPIO_FAST_CLR    = 3'h4;
    localparam logic [2:0]  FGPIO_FAST_RISE   = 3'h5;
    localparam logic [2:0]  FGPIO_FAST_FALL   = 3'h6;
    localparam logic [2:0]  FGPIO_FAST_EVT    = 3'h7;

    // Legacy map: byte address = 0x80 + bank * 0x10 + register offset, banks a and b only
    localparam int          FGPIO_LEG_BANK_LSB = 4;
    localparam logic [1:0]  FGPIO_LEG_PIN     = 2'h0;
    localparam logic [1:0]  FGPIO_LEG_SET     = 2'h1;
    localparam logic [1:0]  FGPIO_LEG_DIR     = 2'h2;
    localparam logic [1:0]  FGPIO_LEG_CLR     = 2'h3;

    // Reset values
    localparam logic [31:0] FGPIO_RST_DIR     = 32'h0000_0000;
    localparam logic [31:0] FGPIO_RST_MASK    = 32'h0000_0000;
    localparam logic [31:0] FGPIO_RST_OUT     = 32'h0000_0000;
    localparam logic [31:0] FGPIO_RST_EDGE_EN = 32'h0000_0000;
    localparam logic [31:0] FGPIO_RST_EVT     = 32'h0000_0000;

    // Edge-capable pins: bank a and bank c, 28 + 14 = 42 pins
    localparam logic [31:0] FGPIO_EDGE_PINS_A = 32'h0FFF_FFFF;
    localparam logic [31:0] FGPIO_EDGE_PINS_B = 32'h0000_0000;
    localparam logic [31:0] FGPIO_EDGE_PINS_C = 32'h0000_3FFF;

endpackage

// [fgpio_top.sv]
// Fast GPIO block: three banks, masked group access, legacy alias, edge events
`timescale 1ns/1ps
// Overview of operation
// - Each pin's direction is chosen per bit and may change at any time.
// - Dedicated set and clear registers raise or lower chosen output bits in one write.
// - Output latch and live pin level are both readable.
// - Mask register excludes masked bits from fast-space group access; legacy alias writes ignore the mask.
// - Byte, half-word and word accesses touch only the addressed lanes.
// - One full-width write loads a whole bank output value.
// - 42 pins on banks a and c request on rising, falling or both edges.
// - Edge detection keeps catching edges independent of bus activity.
// - Any enabled pending edge drives the wake-up request.
// - After reset every pin is an input with drivers off.
// - Legacy copies of banks a and b registers stay reachable at alias addresses.
// - Pin edge requests merge with external interrupt line three.
module fgpio_top
    import fgpio_pkg::*;
#(
    parameter int          NB     = FGPIO_NUM_BANKS,
    parameter int          W      = FGPIO_BANK_WIDTH,
    parameter logic [31:0] EDGE_A = FGPIO_EDGE_PINS_A,
    parameter logic [31:0] EDGE_B = FGPIO_EDGE_PINS_B,
    parameter logic [31:0] EDGE_C = FGPIO_EDGE_PINS_C
)
(
    input  wire logic                        clk_sys_i,
    input  wire logic                        arst_n_i,
    input  wire logic                        ce_i,
    input  wire logic [FGPIO_ADDR_WIDTH-1:0] acc_addr_i,
    input  wire logic [3:0]                  acc_be_i,
    input  wire logic                        acc_wr_i,
    input  wire logic                        acc_rd_i,
    input  wire logic [31:0]                 acc_wdata_i,
    output logic      [31:0]                 acc_rdata_o,
    output logic                             acc_ack_o,
    input  wire logic [NB*W-1:0]             gpio_pin_i,
    output logic      [NB*W-1:0]             gpio_out_o,
    output logic      [NB*W-1:0]             gpio_oe_n_o,
    input  wire logic                        external_irq_line_three_i,
    output logic                             irq_o,
    output logic                             wake_o
);

    logic [W-1:0] dir_q   [NB];
    logic [W-1:0] dir_d   [NB];
    logic [W-1:0] mask_q  [NB];
    logic [W-1:0] mask_d  [NB];
    logic [W-1:0] out_q   [NB];
    logic [W-1:0] out_d   [NB];
    logic [W-1:0] rise_q  [NB];
    logic [W-1:0] rise_d  [NB];
    logic [W-1:0] fall_q  [NB];
    logic [W-1:0] fall_d  [NB];
    logic [W-1:0] evt_q   [NB];
    logic [W-1:0] evt_d   [NB];
    logic [W-1:0] evt_clr [NB];
    logic [W-1:0] rise_ev [NB];
    logic [W-1:0] fall_ev [NB];
    logic [W-1:0] pin1_q  [NB];
    logic [W-1:0] pin2_q  [NB];
    logic [W-1:0] pin3_q  [NB];
    logic         ext1_q;
    logic         ext2_q;
    logic [31:0]  rdata_q;
    logic [31:0]  rdata_d;
    logic         ack_q;
    logic         ack_d;
    logic         irq_q;
    logic         irq_d;
    logic         wake_q;
    logic         wake_d;

    // Byte enables spread to a bit mask
    function automatic logic [31:0] lane_bits(input logic [3:0] be);
        lane_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Replace only the bits selected by sel
    function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] nv,
                                           input logic [W-1:0] sel);
        merge = (old & ~sel) | (nv & sel);
    endfunction

    function automatic logic [W-1:0] edge_cap(input int b);
        logic [31:0] m;
        m = (b == 0) ? EDGE_A : ((b == 2) ? EDGE_C : EDGE_B);
        edge_cap = m[W-1:0];
    endfunction

    // An event counts toward the request only while its pin still has an edge enabled
    function automatic logic armed(input logic [W-1:0] evt, input logic [W-1:0] en);
        armed = |(evt & en);
    endfunction

    // Two-flop pin sync; third stage only feeds edge compare
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int b = 0; b < NB; b++)
            begin
                pin1_q[b] <= '0;
                pin2_q[b] <= '0;
                pin3_q[b] <= '0;
            end
            ext1_q <= 1'b0;
            ext2_q <= 1'b0;
        end
        else if (ce_i)
        begin
            for (int b = 0; b < NB; b++)
            begin
                pin1_q[b] <= gpio_pin_i[b*W +: W];
                pin2_q[b] <= pin1_q[b];
                pin3_q[b] <= pin2_q[b];
            end
            ext1_q <= external_irq_line_three_i;
            ext2_q <= ext1_q;
        end
    end

    always_comb
    begin
        logic                 leg;
        logic [1:0]           fbank;
        logic [1:0]           lbank;
        logic [2:0]           freg;
        logic [1:0]           lreg;
        logic [W-1:0]         lanes;
        logic [W-1:0]         wsel;
        logic [W-1:0]         wd;
        logic [31:0]          be_bits;
        leg     = acc_addr_i[FGPIO_LEGACY_BIT];
        fbank   = acc_addr_i[FGPIO_FAST_BANK_LSB +: 2];
        lbank   = {1'b0, acc_addr_i[FGPIO_LEG_BANK_LSB]};
        freg    = acc_addr_i[4:2];
        lreg    = acc_addr_i[3:2];
        be_bits = lane_bits(acc_be_i);
        lanes   = be_bits[W-1:0];
        wd      = acc_wdata_i[W-1:0];
        wsel    = '0;
        rdata_d = rdata_q;
        // Unmapped addresses still ack, so a stray access never stalls the master
        ack_d   = acc_wr_i | acc_rd_i;
        for (int b = 0; b < NB; b++)
        begin
            dir_d[b]  = dir_q[b];
            mask_d[b] = mask_q[b];
            out_d[b]  = out_q[b];
            rise_d[b] = rise_q[b];
            fall_d[b] = fall_q[b];
            evt_clr[b] = '0;
        end
        // Fast space: masked bits sit out of pin, set and clear writes and read as zero from pin and set
        if (!leg && (int'(fbank) < NB))
        begin
            wsel = lanes & ~mask_q[fbank];
            if (acc_wr_i)
            begin
                case (freg)
                    FGPIO_FAST_DIR:  dir_d[fbank]  = merge(dir_q[fbank], wd, lanes);
                    FGPIO_FAST_MASK: mask_d[fbank] = merge(mask_q[fbank], wd, lanes);
                    FGPIO_FAST_PIN:  out_d[fbank]  = merge(out_q[fbank], wd, wsel);
                    FGPIO_FAST_SET:  out_d[fbank]  = out_q[fbank] | (wd & wsel);
                    FGPIO_FAST_CLR:  out_d[fbank]  = out_q[fbank] & ~(wd & wsel);
                    FGPIO_FAST_RISE: rise_d[fbank] = merge(rise_q[fbank], wd, lanes);
                    FGPIO_FAST_FALL: fall_d[fbank] = merge(fall_q[fbank], wd, lanes);
                    FGPIO_FAST_EVT:  evt_clr[fbank] = wd & lanes;
                    default:         out_d[fbank]  = out_q[fbank];
                endcase
            end
            if (acc_rd_i)
            begin
                case (freg)
                    FGPIO_FAST_DIR:  rdata_d = 32'(dir_q[fbank]);
                    FGPIO_FAST_MASK: rdata_d = 32'(mask_q[fbank]);
                    FGPIO_FAST_PIN:  rdata_d = 32'(pin2_q[fbank] & ~mask_q[fbank]);
                    FGPIO_FAST_SET:  rdata_d = 32'(out_q[fbank] & ~mask_q[fbank]);
                    FGPIO_FAST_RISE: rdata_d = 32'(rise_q[fbank]);
                    FGPIO_FAST_FALL: rdata_d = 32'(fall_q[fbank]);
                    FGPIO_FAST_EVT:  rdata_d = 32'(evt_q[fbank]);
                    default:         rdata_d = 32'h0000_0000;
                endcase
            end
        end
        // Legacy alias of banks a and b: no mask, same storage as the fast copy
        else if (leg && (acc_addr_i[6:5] == 2'h0))
        begin
            if (acc_wr_i)
            begin
                case (lreg)
                    FGPIO_LEG_SET: out_d[lbank] = out_q[lbank] | (wd & lanes);
                    FGPIO_LEG_CLR: out_d[lbank] = out_q[lbank] & ~(wd & lanes);
                    FGPIO_LEG_DIR: dir_d[lbank] = merge(dir_q[lbank], wd, lanes);
                    default:       out_d[lbank] = out_q[lbank];
                endcase
            end
            if (acc_rd_i)
            begin
                case (lreg)
                    FGPIO_LEG_PIN: rdata_d = 32'(pin2_q[lbank]);
                    FGPIO_LEG_SET: rdata_d = 32'(out_q[lbank]);
                    FGPIO_LEG_DIR: rdata_d = 32'(dir_q[lbank]);
                    default:       rdata_d = 32'h0000_0000;
                endcase
            end
        end
        else if (acc_rd_i)
        begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Edges come from the second and third sync stages, never the possibly metastable first
    // Limitation: capture needs the clock running with ce_i high; a pulse under a cycle is lost unless it spans a rising clock edge
    always_comb
    begin
        for (int b = 0; b < NB; b++)
        begin
            rise_ev[b] = edge_cap(b) & rise_q[b] & pin2_q[b] & ~pin3_q[b];
            fall_ev[b] = edge_cap(b) & fall_q[b] & ~pin2_q[b] & pin3_q[b];
        end
    end

    // Clear is applied before capture, so an edge in the clearing cycle is kept
    always_comb
    begin
        logic pend;
        pend = 1'b0;
        for (int b = 0; b < NB; b++)
        begin
            evt_d[b] = (evt_q[b] & ~evt_clr[b]) | rise_ev[b] | fall_ev[b];
            pend     = pend | armed(evt_q[b], rise_q[b] | fall_q[b]);
        end
        irq_d  = pend | ext2_q;
        wake_d = pend;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int b = 0; b < NB; b++)
            begin
                evt_q[b] <= FGPIO_RST_EVT[W-1:0];
            end
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end
        else if (ce_i)
        begin
            evt_q  <= evt_d;
            irq_q  <= irq_d;
            wake_q <= wake_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int b = 0; b < NB; b++)
            begin
                dir_q[b]  <= FGPIO_RST_DIR[W-1:0];
                mask_q[b] <= FGPIO_RST_MASK[W-1:0];
                out_q[b]  <= FGPIO_RST_OUT[W-1:0];
                rise_q[b] <= FGPIO_RST_EDGE_EN[W-1:0];
                fall_q[b] <= FGPIO_RST_EDGE_EN[W-1:0];
            end
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
        end
        else if (ce_i)
        begin
            dir_q   <= dir_d;
            mask_q  <= mask_d;
            out_q   <= out_d;
            rise_q  <= rise_d;
            fall_q  <= fall_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
        end
    end

    // Pins driven only where direction is output; enable is active low
    always_comb
    begin
        for (int b = 0; b < NB; b++)
        begin
            gpio_out_o[b*W +: W]  = out_q[b];
            gpio_oe_n_o[b*W +: W] = ~dir_q[b];
        end
    end

    assign acc_rdata_o = rdata_q;
    assign acc_ack_o   = ack_q;
    assign irq_o       = irq_q;
    assign wake_o      = wake_q;

endmodule

// [fgpio_pin_model.sv]
// External pin model: resolves driven and released pins
`timescale 1ns/1ps
module fgpio_pin_model
(
    input  wire logic [95:0] gpio_out_i,
    input  wire logic [95:0] gpio_oe_n_i,
    input  wire logic [95:0] ext_drv_i,
    output logic      [95:0] gpio_pin_o
);
    // Driven pins show the latch, released pins follow the outside source
    assign gpio_pin_o = (gpio_oe_n_i & ext_drv_i) | (~gpio_oe_n_i & gpio_out_i);
endmodule

// [fgpio_checker.sv]
// Port checker for the fast GPIO block
`timescale 1ns/1ps
module fgpio_checker
    import fgpio_pkg::*;
#(
    parameter int NB = FGPIO_NUM_BANKS,
    parameter int W  = FGPIO_BANK_WIDTH
)
(
    input wire logic                        clk_sys_i,
    input wire logic                        arst_n_i,
    input wire logic                        ce_i,
    input wire logic [FGPIO_ADDR_WIDTH-1:0] acc_addr_i,
    input wire logic [3:0]                  acc_be_i,
    input wire logic                        acc_wr_i,
    input wire logic                        acc_rd_i,
    input wire logic [31:0]                 acc_wdata_i,
    input wire logic [31:0]                 acc_rdata_o,
    input wire logic                        acc_ack_o,
    input wire logic [NB*W-1:0]             gpio_pin_i,
    input wire logic [NB*W-1:0]             gpio_out_o,
    input wire logic [NB*W-1:0]             gpio_oe_n_o,
    input wire logic                        external_irq_line_three_i,
    input wire logic                        irq_o,
    input wire logic                        wake_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    logic tw;
    assign tw = ce_i && acc_wr_i && !acc_rd_i;
    a_ack_per_access: assert property (ce_i |=> acc_ack_o == $past(acc_wr_i || acc_rd_i))
        else $error("ack does not follow access");
    a_rdata_holds: assert property (!(ce_i && acc_rd_i) |=> $stable(acc_rdata_o))
        else $error("read data changed without read");
    a_leg_set: assert property (tw && acc_addr_i == 8'h84 && acc_be_i == 4'hF
        |=> gpio_out_o[31:0] == ($past(gpio_out_o[31:0]) | $past(acc_wdata_i)))
        else $error("legacy set wrong");
    a_leg_clear: assert property (tw && acc_addr_i == 8'h8C && acc_be_i == 4'hF
        |=> gpio_out_o[31:0] == ($past(gpio_out_o[31:0]) & ~$past(acc_wdata_i)))
        else $error("legacy clear wrong");
    a_leg_dir: assert property (tw && acc_addr_i == 8'h88 && acc_be_i == 4'hF
        |=> gpio_oe_n_o[31:0] == ~$past(acc_wdata_i)) else $error("legacy direction wrong");
    a_lane_keep: assert property (tw && acc_addr_i[7] && acc_be_i == 4'h1
        |=> $stable(gpio_out_o[31:8])) else $error("unaddressed lanes changed");
    a_reset_inputs: assert property ($past(!arst_n_i) |-> &gpio_oe_n_o && gpio_out_o == '0)
        else $error("pins not inputs after reset");
    a_wake_sticky: assert property (wake_o && !acc_wr_i && !$past(acc_wr_i) |=> wake_o)
        else $error("pending event lost");
    a_wake_in_irq: assert property (wake_o |-> irq_o)
        else $error("edge request not merged");
    a_ext_irq: assert property ((ce_i && external_irq_line_three_i)[*5] |-> irq_o)
        else $error("external line not merged");
    c_wake: cover property (wake_o);
    c_ext_only: cover property (irq_o && !wake_o);
    c_byte_set: cover property (tw && acc_addr_i == 8'h84 && acc_be_i == 4'h1);
endmodule
bind fgpio_top fgpio_checker #(.NB(NB), .W(W)) fgpio_checker_i (.*);

// [fgpio_top_tb_top.sv]
// Testbench for the fast GPIO block
`timescale 1ns/1ps
module fgpio_top_tb_top;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        ce_i = 1'b1;
    logic [7:0]  acc_addr_i = 8'h00;
    logic [3:0]  acc_be_i = 4'h0;
    logic        acc_wr_i = 1'b0;
    logic        acc_rd_i = 1'b0;
    logic [31:0] acc_wdata_i = 32'h0;
    logic        external_irq_line_three_i = 1'b0;
    logic [95:0] ext = 96'h0;
    logic [95:0] gpio_pin_i, gpio_out_o, gpio_oe_n_o;
    logic [31:0] acc_rdata_o, q;
    logic        acc_ack_o, irq_o, wake_o;
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;
    fgpio_top fgpio_top_i (.*);
    fgpio_pin_model fgpio_pin_model_i (.gpio_out_i(gpio_out_o), .gpio_oe_n_i(gpio_oe_n_o),
        .ext_drv_i(ext), .gpio_pin_o(gpio_pin_i));
    initial forever #50 clk_sys_i = ~clk_sys_i;
    // Ceiling well above the roughly 100 cycles the tests need
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
            final_report(1);
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks = checks + 1;
        if (s !== e)
        begin
            failures = failures + 1;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // Strobe is a one-cycle pulse, so it drops at the edge that takes it
    task automatic acc(input logic [7:0] a, input logic [3:0] b, input logic w,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        acc_addr_i <= a;
        acc_be_i <= b;
        acc_wr_i <= w;
        acc_rd_i <= ~w;
        acc_wdata_i <= d;
        @(posedge clk_sys_i);
        acc_wr_i <= 1'b0;
        acc_rd_i <= 1'b0;
        #1;
        chk("ack", {31'h0, acc_ack_o}, 32'h1);
        q = acc_rdata_o;
    endtask
    task automatic t_direction();
        chk("oe_n", {31'h0, &gpio_oe_n_o}, 32'h1);
        chk("rst_out", {31'h0, |gpio_out_o}, 32'h0);
        acc(8'h00, 4'hF, 1'b1, 32'hFFFF_FFFF);
        chk("oe_a", gpio_oe_n_o[31:0], 32'h0);
        acc(8'h08, 4'hF, 1'b1, 32'h1234_5678);
        chk("full_write", gpio_out_o[31:0], 32'h1234_5678);
        @(posedge clk_sys_i);
        ext <= {32'h2, 32'h0, 32'h5A5A_0001};
        tick(4);
        acc(8'h08, 4'hF, 1'b0, 32'h0);
        chk("pin_driven", q, 32'h1234_5678);
        acc(8'h88, 4'hF, 1'b1, 32'h0);
        tick(4);
        acc(8'h80, 4'hF, 1'b0, 32'h0);
        chk("pin_ext", q, 32'h5A5A_0001);
        $display("test direction done");
    endtask
    task automatic t_group();
        acc(8'h04, 4'hF, 1'b1, 32'h0000_FF00);
        acc(8'h0C, 4'hF, 1'b1, 32'hFFFF_FFFF);
        chk("set_mask", gpio_out_o[31:0], 32'hFFFF_56FF);
        acc(8'h10, 4'hF, 1'b1, 32'h0F0F_0F0F);
        chk("clr_mask", gpio_out_o[31:0], 32'hF0F0_56F0);
        acc(8'h0C, 4'hF, 1'b0, 32'h0);
        chk("latch_rd", q, 32'hF0F0_00F0);
        acc(8'h04, 4'hF, 1'b1, 32'h0);
        acc(8'h08, 4'hC, 1'b1, 32'hAAAA_AAAA);
        chk("half_lane", gpio_out_o[31:0], 32'hAAAA_56F0);
        acc(8'h84, 4'h1, 1'b1, 32'hFFFF_FF0F);
        chk("byte_lane", gpio_out_o[31:0], 32'hAAAA_56FF);
        acc(8'h84, 4'hF, 1'b1, 32'h0000_0100);
        acc(8'h8C, 4'hF, 1'b1, 32'hAAAA_0000);
        chk("leg_clr", gpio_out_o[31:0], 32'h0000_57FF);
        acc(8'h94, 4'hF, 1'b1, 32'h0000_0003);
        chk("leg_b", gpio_out_o[63:32], 32'h3);
        acc(8'hA0, 4'hF, 1'b0, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test group done");
    endtask
    task automatic t_edges();
        acc(8'h5C, 4'hF, 1'b1, 32'hFFFF_FFFF);
        acc(8'h1C, 4'hF, 1'b1, 32'hFFFF_FFFF);
        acc(8'h54, 4'hF, 1'b1, 32'h1);
        acc(8'h58, 4'hF, 1'b1, 32'h2);
        acc(8'h18, 4'hF, 1'b1, 32'h1000_0000);
        @(posedge clk_sys_i);
        ext[65:64] <= 2'h1;
        // Falling edge on a bank a pin outside the capable set
        ext[28] <= 1'b0;
        tick(6);
        chk("req", {30'h0, irq_o, wake_o}, 32'h3);
        acc(8'h5C, 4'hF, 1'b0, 32'h0);
        chk("evt_c", q, 32'h3);
        acc(8'h1C, 4'hF, 1'b0, 32'h0);
        chk("evt_a", q, 32'h0);
        acc(8'h5C, 4'hF, 1'b1, 32'h1);
        tick(3);
        chk("one_left", {31'h0, wake_o}, 32'h1);
        acc(8'h5C, 4'hF, 1'b1, 32'h2);
        tick(3);
        chk("cleared", {30'h0, irq_o, wake_o}, 32'h0);
        @(posedge clk_sys_i);
        external_irq_line_three_i <= 1'b1;
        tick(6);
        chk("ext_irq", {30'h0, irq_o, wake_o}, 32'h2);
        $display("test edges done");
    endtask
    task automatic final_report(input int extra);
        failures = failures + extra;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        tick(1);
        t_direction();
        t_group();
        t_edges();
        final_report(0);
    end
endmodule
